// File: hdl/sar_ctl_pkg.sv
// Shared constants for the converter control and its host end
package sar_ctl_pkg;
  // Clock and timing figures
  localparam int MCLK_HZ        = 100_000_000;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int CONV_CLK_HZ    = 640_000;
  localparam int CONV_DIV       = MCLK_HZ / CONV_CLK_HZ;
  localparam int TRIG_MIN_NS    = 200;
  localparam int ALE_MIN_NS     = 200;
  localparam int ADDR_SETUP_NS  = 50;
  localparam int MUX_SETTLE_NS  = 2500;
  localparam int OE_ACCESS_NS   = 250;
  // Least times round up to whole cycles
  localparam int TRIG_CYC       = (TRIG_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int ALE_CYC        = (ALE_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SETUP_CYC      = (ADDR_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SETTLE_CYC     = (MUX_SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int OE_CYC         = (OE_ACCESS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // Approximation shape
  localparam int RES_BITS       = 8;
  localparam int CHAN_BITS      = 3;
  localparam int CYC_PER_BIT    = 8;
  localparam int CONV_CYCLES    = RES_BITS * CYC_PER_BIT;
  localparam int SYNC_STAGES    = 3;
  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
endpackage

// File: hdl/sar_link_if.sv
// Pin-level link between the host end and the converter end
`timescale 1ns/100ps
`default_nettype none
interface sar_link_if;
  logic       ale;
  logic [2:0] addr;
  logic       conversion_trigger_input;
  logic       oe;
  logic       eoc;
  logic [7:0] data_q;
  logic       data_oe_n;
  wire  [7:0] data_bus;

  // Data wire seen by the host; released lines read as the inverse of the
  // result, so a host sampling before the access time gets wrong data
  assign data_bus = data_oe_n ? ~data_q : data_q;

  modport dev (
    input  ale,
    input  addr,
    input  conversion_trigger_input,
    input  oe,
    output eoc,
    output data_q,
    output data_oe_n
  );
  modport host (
    output ale,
    output addr,
    output conversion_trigger_input,
    output oe,
    input  eoc,
    input  data_bus
  );
endinterface
`default_nettype wire

// File: hdl/sar_conv_dev.sv
// Converter end: channel latch, approximation sequencer, result register
// Overview of operation
// - Rising strobe edge latches channel address
// - Address value n selects analog input n
// - Eight iterations, one bit each, MSB first
// - Trigger rising edge clears approximation register
// - Sequence starts on trigger falling edge
// - New trigger aborts and restarts conversion
// - Done fed back to trigger free-runs
// - Host kicks free-running loop on each rise of free_run seen in idle
// - Done drops within eight clocks of trigger
// - Result loads one clock before done rises
// - Result is straight positive-true binary
// - Host holds trigger high at least 200 ns on a command or free-run kick
// - Host holds strobe high at least 200 ns
// - Host waits 2.5 us after new channel
// - Data driven only while output enabled
`timescale 1ns/100ps
`default_nettype none
module sar_conv_dev #(
  parameter int DIV = sar_ctl_pkg::CONV_DIV
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  sar_link_if.dev         link,
  input  wire logic       comp_high,
  output var  logic [7:0] dac_code,
  output var  logic [7:0] analog_input_n_en,
  output var  logic       busy
);
  localparam int NB = sar_ctl_pkg::RES_BITS;

  if (DIV < 2 || DIV > 65535) begin : g_chk
    $error("DIV out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_LOAD, ST_FIN} state_t;

  // Mask selecting the bit under trial
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // Pin synchronisers: oe, trigger, strobe, address
  logic [5:0]  s1_r;
  logic [5:0]  s2_r;
  logic [5:0]  s3_r;
  logic [5:0]  filt_r;
  logic [5:0]  filt_prev_r;
  logic [5:0]  filt_nxt;
  logic [15:0] div_cnt_r;
  logic        tick_r;
  state_t      state_r;
  logic [5:0]  step_r;
  logic [7:0]  sar_r;
  logic [7:0]  data_r;
  logic [2:0]  chan_r;
  logic        eoc_r;
  logic        drop_pend_r;
  logic        oe_r;
  logic [7:0]  dout_r;
  logic [7:0]  dac_r;
  logic [7:0]  sel_r;
  logic        busy_r;

  // Level counts only once second and third stage agree
  assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));

  always_ff @(posedge mclk) begin
    s1_r <= {link.oe, link.conversion_trigger_input, link.ale, link.addr};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      filt_r      <= 6'h00;
      filt_prev_r <= 6'h00;
    end else begin
      filt_r      <= filt_nxt;
      filt_prev_r <= filt_r;
    end
  end

  // Decoded pin events
  wire       oe_lvl    = filt_r[5];
  wire       trig_rise = filt_r[4] & ~filt_prev_r[4];
  wire       trig_fall = ~filt_r[4] & filt_prev_r[4];
  wire       ale_rise  = filt_r[3] & ~filt_prev_r[3];
  wire [2:0] addr_lvl  = filt_r[2:0];

  // Free-running conversion clock enable; never gated, so a tick is due
  // within one conversion period of any trigger edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end else if (div_cnt_r == 16'(DIV - 1)) begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      tick_r    <= 1'b0;
    end
  end

  // Channel latch and one-hot input select
  wire [7:0] sel_nxt = bit_mask(chan_r);

  always_ff @(posedge mclk) begin
    if (srst) begin
      chan_r <= sar_ctl_pkg::CHAN_RST;
      sel_r  <= 8'h01;
    end else begin
      if (ale_rise) begin
        chan_r <= addr_lvl;
      end
      sel_r <= sel_nxt;
    end
  end

  // Trial arithmetic: bit index counts down from MSB every eight ticks
  wire [2:0] bit_idx   = 3'(NB - 1) - step_r[5:3];
  wire       bit_last  = step_r[2:0] == 3'h7;
  wire       seq_last  = step_r == 6'(sar_ctl_pkg::CONV_CYCLES - 1);
  wire [7:0] trial     = sar_r | bit_mask(bit_idx);
  wire [7:0] decided   = comp_high ? trial : sar_r;

  // Sequencer; a trigger rising edge overrides whatever is in progress
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      step_r  <= 6'h00;
      sar_r   <= 8'h00;
      data_r  <= sar_ctl_pkg::DATA_RST;
    end else if (trig_rise) begin
      state_r <= ST_ARMED;
      step_r  <= 6'h00;
      sar_r   <= 8'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_ARMED: begin
          if (trig_fall) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick_r) begin
            step_r <= step_r + 6'h01;
            if (bit_last) begin
              sar_r <= decided;
            end
            if (seq_last) begin
              state_r <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (tick_r) begin
            data_r  <= sar_r;
            state_r <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (tick_r) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Done flag: dropped on the first tick after a trigger rise, raised one
  // tick after the result load. Feeding it back to the trigger gives a
  // trigger pulse of at most one conversion period plus the synchroniser delays.
  wire eoc_set   = tick_r & (state_r == ST_FIN) & ~trig_rise;
  wire eoc_clear = tick_r & drop_pend_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      eoc_r       <= 1'b0;
      drop_pend_r <= 1'b0;
    end else begin
      drop_pend_r <= trig_rise | (drop_pend_r & ~tick_r);
      if (eoc_clear) begin
        eoc_r <= 1'b0;
      end else if (eoc_set) begin
        eoc_r <= 1'b1;
      end
    end
  end

  // Output stage: data and its enable from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      oe_r   <= 1'b0;
      dout_r <= sar_ctl_pkg::DATA_RST;
      dac_r  <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      oe_r   <= oe_lvl;
      dout_r <= data_r;
      dac_r  <= (state_r == ST_RUN) ? trial : sar_r;
      busy_r <= state_r != ST_IDLE;
    end
  end

  assign link.eoc          = eoc_r;
  assign link.data_q       = dout_r;
  assign link.data_oe_n    = ~oe_r;
  assign dac_code          = dac_r;
  assign analog_input_n_en = sel_r;
  assign busy              = busy_r;
endmodule // sar_conv_dev
`default_nettype wire

// File: hdl/sar_conv_host.sv
// Host end: drives strobe, trigger and output enable, collects results
`timescale 1ns/100ps
`default_nettype none
module sar_conv_host (
  input  wire logic       mclk,
  input  wire logic       srst,
  sar_link_if.host        link,
  input  wire logic [2:0] cmd_chan,
  input  wire logic       cmd_sel,
  input  wire logic       cmd_conv,
  input  wire logic       cmd_read,
  input  wire logic       free_run,
  output var  logic       busy,
  output var  logic       conv_done,
  output var  logic       rd_valid,
  output var  logic [7:0] rd_data
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_ALE, H_SETTLE, H_TRIG, H_OE} hstate_t;

  hstate_t    state_r;
  logic [9:0] cnt_r;
  logic       ale_r;
  logic [2:0] addr_r;
  logic       start_r;
  logic       oe_r;
  logic       busy_r;
  logic       rd_valid_r;
  logic [7:0] rd_data_r;
  logic       fr_prev_r;
  logic [8:0] s1_r;
  logic [8:0] s2_r;
  logic [8:0] s3_r;
  logic [8:0] filt_r;

  // Pin synchronisers for done and data wire
  always_ff @(posedge mclk) begin
    s1_r <= {link.eoc, link.data_bus};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      filt_r <= 9'h000;
    end else begin
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
    end
  end

  wire       eoc_lvl  = filt_r[8];
  wire       fr_kick  = free_run & ~fr_prev_r;
  wire       cnt_done = cnt_r == 10'h000;
  // Access time plus synchroniser delay before sampling
  wire [9:0] oe_wait  = 10'(sar_ctl_pkg::OE_CYC + sar_ctl_pkg::SYNC_STAGES);

  // Command sequencer; commands outside idle are ignored
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r    <= H_IDLE;
      cnt_r      <= 10'h000;
      ale_r      <= 1'b0;
      addr_r     <= 3'h0;
      start_r    <= 1'b0;
      oe_r       <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= 8'h00;
      fr_prev_r  <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      fr_prev_r  <= free_run;
      if (!cnt_done) begin
        cnt_r <= cnt_r - 10'h001;
      end
      unique case (state_r)
        H_IDLE: begin
          if (cmd_sel) begin
            addr_r  <= cmd_chan;
            cnt_r   <= 10'(sar_ctl_pkg::SETUP_CYC);
            state_r <= H_SETUP;
          end else if (cmd_conv || fr_kick) begin
            start_r <= 1'b1;
            cnt_r   <= 10'(sar_ctl_pkg::TRIG_CYC);
            state_r <= H_TRIG;
          end else if (cmd_read) begin
            oe_r    <= 1'b1;
            cnt_r   <= oe_wait;
            state_r <= H_OE;
          end else begin
            // Leaving free run drops the fed-back trigger, so a pulse that
            // was high when the loop stopped cannot hold the converter armed
            start_r <= free_run & eoc_lvl;
          end
        end
        H_SETUP: begin
          if (cnt_done) begin
            ale_r   <= 1'b1;
            cnt_r   <= 10'(sar_ctl_pkg::ALE_CYC);
            state_r <= H_ALE;
          end
        end
        H_ALE: begin
          if (cnt_done) begin
            ale_r   <= 1'b0;
            cnt_r   <= 10'(sar_ctl_pkg::SETTLE_CYC);
            state_r <= H_SETTLE;
          end
        end
        H_SETTLE: begin
          if (cnt_done) begin
            state_r <= H_IDLE;
          end
        end
        H_TRIG: begin
          if (cnt_done) begin
            start_r <= 1'b0;
            state_r <= H_IDLE;
          end
        end
        H_OE: begin
          if (cnt_done) begin
            oe_r       <= 1'b0;
            rd_data_r  <= filt_r[7:0];
            rd_valid_r <= 1'b1;
            state_r    <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Status flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= state_r != H_IDLE;
    end
  end

  assign link.ale                      = ale_r;
  assign link.addr                     = addr_r;
  assign link.conversion_trigger_input = start_r;
  assign link.oe                       = oe_r;
  assign busy                          = busy_r;
  assign conv_done                     = filt_r[8];
  assign rd_valid                      = rd_valid_r;
  assign rd_data                       = rd_data_r;
endmodule // sar_conv_host
`default_nettype wire

// File: sim/sar_link_props.sv
// Link-level properties watched beside the converter link
`timescale 1ns/100ps
`default_nettype none
module sar_link_props #(
  parameter int DIV = 4
) (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       ale,
  input wire logic       conversion_trigger_input,
  input wire logic       oe,
  input wire logic       eoc,
  input wire logic [7:0] data_q,
  input wire logic       data_oe_n,
  input wire logic [7:0] data_bus
);
  // Windows in mclk cycles; the input synchronisers add about six
  localparam int EOC_MAX  = 8 * DIV + 6;
  localparam int RUN_MIN  = 64 * DIV;
  localparam int RUN_MAX  = 68 * DIV + 12;
  localparam int LOAD_MAX = DIV + 1;
  localparam int OE_MAX   = 25;
  logic [15:0] rise_cnt_r;
  logic [15:0] fall_cnt_r;
  logic [15:0] ale_hi_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Saturating counters, so long idle spans never wrap to small values
  always_ff @(posedge mclk) begin
    if (srst) begin
      rise_cnt_r <= 16'h0000;
      fall_cnt_r <= 16'h0000;
      ale_hi_r   <= 16'h0000;
    end else begin
      rise_cnt_r <= $rose(conversion_trigger_input) ? 16'h0000 : rise_cnt_r + {15'h0000, ~&rise_cnt_r};
      fall_cnt_r <= $fell(conversion_trigger_input) ? 16'h0000 : fall_cnt_r + {15'h0000, ~&fall_cnt_r};
      ale_hi_r   <= ale ? ale_hi_r + {15'h0000, ~&ale_hi_r} : 16'h0000;
    end
  end
  // Result load is followed by the done flag one conversion tick later
  sequence done_after_load;
    ##[1:LOAD_MAX] $rose(eoc);
  endsequence
  eoc_drop_a: assert property ($rose(conversion_trigger_input) |-> ##[0:EOC_MAX] !eoc)
    else $error("done did not drop after trigger");
  eoc_hold_a: assert property ($fell(eoc) |-> rise_cnt_r <= EOC_MAX)
    else $error("done dropped without a trigger");
  run_len_a: assert property ($rose(eoc) |-> !conversion_trigger_input && fall_cnt_r >= RUN_MIN)
    else $error("done rose too early");
  run_done_a: assert property ($fell(conversion_trigger_input) |-> ##[1:RUN_MAX] (eoc || conversion_trigger_input))
    else $error("conversion did not complete");
  load_a: assert property ($changed(data_q) |-> done_after_load)
    else $error("result changed without completion");
  oe_on_a: assert property ($rose(oe) |-> ##[1:OE_MAX] !data_oe_n)
    else $error("data not driven after enable");
  oe_off_a: assert property ($fell(oe) |-> ##[1:OE_MAX] data_oe_n)
    else $error("data still driven after enable");
  bus_value_a: assert property (!data_oe_n |-> data_bus == data_q)
    else $error("bus differs from result");
  ale_width_a: assert property ($fell(ale) |-> ale_hi_r >= sar_ctl_pkg::ALE_CYC)
    else $error("strobe pulse too short");
endmodule // sar_link_props
`default_nettype wire

// File: sim/sar_adc_mux_control_bench.sv
// Bench joining host end and converter end across the link
`timescale 1ns/100ps
`default_nettype none
module sar_adc_mux_control_bench;
  logic       mclk;
  logic       srst;
  logic       comp_high;
  logic [7:0] dac_code;
  logic [7:0] sel_en;
  logic       dev_busy;
  logic [2:0] cmd_chan;
  logic       cmd_sel;
  logic       cmd_conv;
  logic       cmd_read;
  logic       free_run;
  logic       host_busy;
  logic       conv_done;
  logic       rd_valid;
  logic [7:0] rd_data;
  int         error_cnt = 0;
  int         compares = 0;
  int         n;
  int         rd_pulses = 0;
  logic [7:0] vin [8] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h01, 8'h80, 8'h7F, 8'hC3};
  sar_link_if sar_link_if_i ();
  sar_conv_dev #(.DIV(4)) sar_conv_dev_i (.mclk(mclk), .srst(srst), .link(sar_link_if_i.dev),
    .comp_high(comp_high), .dac_code(dac_code), .analog_input_n_en(sel_en), .busy(dev_busy));
  sar_conv_host sar_conv_host_i (.mclk(mclk), .srst(srst), .link(sar_link_if_i.host), .cmd_chan(cmd_chan),
    .cmd_sel(cmd_sel), .cmd_conv(cmd_conv), .cmd_read(cmd_read), .free_run(free_run), .busy(host_busy),
    .conv_done(conv_done), .rd_valid(rd_valid), .rd_data(rd_data));
  sar_link_props #(.DIV(4)) sar_link_props_i (.mclk(mclk), .srst(srst), .ale(sar_link_if_i.ale),
    .conversion_trigger_input(sar_link_if_i.conversion_trigger_input), .oe(sar_link_if_i.oe),
    .eoc(sar_link_if_i.eoc), .data_q(sar_link_if_i.data_q), .data_oe_n(sar_link_if_i.data_oe_n),
    .data_bus(sar_link_if_i.data_bus));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Ideal comparator: selected input against the trial code
  always @(negedge mclk) begin
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (sel_en[i] && vin[i] >= dac_code) begin
        hit = 1'b1;
      end
    end
    comp_high <= hit;
  end
  // Read strobes counted away from the edge that launches them
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      rd_pulses++;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Busy rises a cycle late, so give it time before polling
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (3) @(negedge mclk);
    while (host_busy !== 1'b0 && k < 5000) begin
      @(negedge mclk);
      k++;
    end
    check("host_idle", {7'h00, host_busy}, 8'h00);
  endtask
  // Kind bits: 1 select, 2 convert, 4 read
  task automatic issue(input logic [2:0] kind, input logic [2:0] ch);
    @(negedge mclk);
    cmd_chan = ch;
    {cmd_read, cmd_conv, cmd_sel} = kind;
    @(negedge mclk);
    {cmd_read, cmd_conv, cmd_sel} = 3'h0;
    wait_idle();
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (conv_done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    check("conv_done", {7'h00, conv_done}, 8'h01);
  endtask
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {srst, cmd_chan, cmd_sel, cmd_conv, cmd_read, free_run} = 8'h80;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    for (int c = 0; c < 8; c++) begin
      issue(3'h1, c[2:0]);
      check("channel", sel_en, 8'(8'h01 << c));
      issue(3'h2, 3'h0);
      wait_done();
      check("dac_idle", dac_code, vin[c]);
      check("dev_idle", {7'h00, dev_busy}, 8'h00);
      check("bus_idle", {7'h00, sar_link_if_i.data_oe_n}, 8'h01);
      issue(3'h4, 3'h0);
      check("result", rd_data, vin[c]);
    end
    // Read mid-run sees the old result, then a retrigger restarts the run
    issue(3'h1, 3'h2);
    issue(3'h2, 3'h0);
    issue(3'h4, 3'h0);
    check("held_result", rd_data, vin[7]);
    check("done_low", {7'h00, conv_done}, 8'h00);
    check("dev_running", {7'h00, dev_busy}, 8'h01);
    issue(3'h2, 3'h0);
    wait_done();
    issue(3'h4, 3'h0);
    check("restart_result", rd_data, vin[2]);
    // Done fed back to the trigger keeps converting on its own
    free_run = 1'b1;
    n = 0;
    for (int k = 0; k < 3000 && n < 3; k++) begin
      @(negedge mclk);
      if (conv_done === 1'b0) n += (k > 0 && n % 2 == 0) ? 1 : 0;
      if (conv_done === 1'b1) n += (n % 2 == 1) ? 1 : 0;
    end
    check("free_run_steps", 8'(n), 8'h03);
    free_run = 1'b0;
    repeat (20) @(negedge mclk);
    wait_done();
    wait_idle();
    issue(3'h4, 3'h0);
    check("free_result", rd_data, vin[2]);
    check("read_pulses", 8'(rd_pulses), 8'h0B);
    finish_test();
  end
endmodule // sar_adc_mux_control_bench
`default_nettype wire
